// >>> include/gss_pkg.sv
// shared constants and types for the gauge status spi output path
// assumes one 10 MHz system clock; spi pins are sampled synchronously
package gss_pkg;
   localparam int WORD_BITS = 16;           // spi word length
   localparam int CNT_BITS = 16;            // received bit counter width
   localparam logic [3:0] SEL_RESET = 4'h0; // device status after reset
   // select field decode positions within the received word
   localparam int SEL_HI = 11;
   localparam int SEL_LO = 8;
   // device status bit positions
   localparam int B_HEAD1 = 15;
   localparam int B_HEAD0 = 14;
   localparam int B_ZS1 = 13;
   localparam int B_ZS0 = 12;
   localparam int B_TP1 = 11;
   localparam int B_TP0 = 10;
   localparam int B_OV = 9;
   localparam int B_UV = 8;
   localparam int B_CAL = 7;
   localparam int B_ANY = 6;
   localparam int B_POSITION_CHANGED_G1 = 5;
   localparam int B_POSITION_CHANGED_G0 = 4;
   localparam int B_HOME1 = 3;
   localparam int B_HOME0 = 2;
   localparam int B_OT1 = 1;
   localparam int B_OT0 = 0;
   // status word kinds
   typedef enum logic [2:0] {
      GSS_DEVICE, GSS_ACCUM, GSS_POS0, GSS_POS1, GSS_VEL
   } gss_kind_t;
   // map the four-bit select field onto a status kind
   function automatic gss_kind_t gss_decode(input logic [3:0] sel);
      gss_kind_t k;
      k = GSS_DEVICE;
      if (!sel[3]) k = GSS_DEVICE;
      else if (!sel[2]) k = GSS_ACCUM;
      else if (!sel[1]) k = sel[0] ? GSS_POS1 : GSS_POS0;
      else k = GSS_VEL;
      return k;
   endfunction
endpackage

// >>> design/gss_fault_hold.sv
// one sticky fault flag: set by hardware, cleared by a valid status read
// assumes set and clear are single-cycle qualified levels of sys_clk
module gss_fault_hold
   import gss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic set_in,
   input wire logic clr_in,
   output logic flag
);
   typedef struct packed {
      logic f;
   } gss_fh_t;
   gss_fh_t s_q, s_d;
   // set wins over a simultaneous clear so no event is lost
   always_comb begin
      s_d = s_q;
      if (clr_in) s_d.f = 1'b0;
      if (set_in) s_d.f = 1'b1;
   end
   // register state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) s_q <= '0;
      else s_q <= s_d;
   end
   assign flag = s_q.f;
endmodule

// >>> design/gss_edge.sv
// rise and fall detector for a synchronous pin level
// assumes the pin is already synchronous to sys_clk
module gss_edge
   import gss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic prev;
   } gss_ed_t;
   gss_ed_t s_q, s_d;
   // remember last level; idle high
   always_comb begin
      s_d.prev = pin;
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) s_q <= '{prev: 1'b1};
      else s_q <= s_d;
   end
   assign rise = pin & ~s_q.prev;
   assign fall = ~pin & s_q.prev;
endmodule

// >>> design/gss_status_spi.sv
// spi slave readback path: status select, shift out, length check
// assumes cs_n, sclk, si synchronous to sys_clk; spi mode 0
// (data changes after falling sclk, sampled on rising sclk)
module gss_status_spi
   import gss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   output logic so_o,
   output logic so_oe_n,
   // live pointer and configuration state
   input wire logic heading_g1,
   input wire logic heading_g0,
   input wire logic zero_side_g1,
   input wire logic zero_side_g0,
   input wire logic target_pending_g1,
   input wire logic target_pending_g0,
   input wire logic homing_active_g1,
   input wire logic homing_active_g0,
   input wire logic clk_cal_bad,
   input wire logic [15:0] accum_word,
   input wire logic [15:0] pos_word_g0,
   input wire logic [15:0] pos_word_g1,
   input wire logic [15:0] vel_word,
   // fault events
   input wire logic supply_high_evt,
   input wire logic supply_low_evt,
   input wire logic supply_deep_low,
   input wire logic thermal_evt_g1,
   input wire logic thermal_evt_g0,
   input wire logic position_step_g1,
   input wire logic position_step_g0,
   input wire logic enable_g1_evt,
   input wire logic enable_g0_evt,
   // outputs toward the rest of the device
   output logic drivers_off,
   output logic motion_reset,
   output logic msg_valid,
   output logic [15:0] msg_word,
   output logic [3:0] status_select_field
);
   // register state of this block, apart from the fault hold and chip select edge instances
   typedef struct packed {
      logic [15:0] shreg;      // outgoing shift register
      logic [15:0] rxw;        // last 16 received bits
      logic [CNT_BITS-1:0] nbits; // bits received this frame
      logic sclk_p;            // previous sclk
      logic in_frame;          // chip select active
      logic dev_sel_frame;     // frame began with device word selected
      logic so;                // so data
      logic oe_n;              // so enable, low drives
      logic [3:0] sel;         // status_select_field
      logic drv_off;           // driver disable
      logic mreset;            // motion reset
      logic mvalid;            // message accepted pulse
      logic [15:0] mword;      // accepted word
      logic [1:0] ot;          // thermal trip latches
   } gss_st_t;
   gss_st_t s_q, s_d;
   logic cs_rise, cs_fall;       // chip select edges
   logic f_ov, f_uv, f_any;      // held supply flags
   logic f_mv1, f_mv0;           // held movement flags
   logic clr_faults;             // valid read of device word
   logic len_ok;                 // message length valid
   logic [15:0] dev_word;        // assembled device status
   logic [15:0] sel_word;        // currently selected word
   logic sclk_rise, sclk_fall;   // serial clock edges

   // chip select edge detection
   gss_edge u_cs (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin(cs_n),
      .rise(cs_rise),
      .fall(cs_fall)
   );

   // length nonzero and a whole multiple of the word size
   assign len_ok = (s_q.nbits != '0) &&
      (s_q.nbits[3:0] == 4'h0);
   // faults drop only after a valid frame that read the device word
   assign clr_faults = cs_rise && len_ok && s_q.dev_sel_frame;
   assign sclk_rise = sclk & ~s_q.sclk_p;
   assign sclk_fall = ~sclk & s_q.sclk_p;

   // held since-last-device-read flags
   gss_fault_hold u_ov (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_in(supply_high_evt),
      .clr_in(clr_faults),
      .flag(f_ov)
   );
   gss_fault_hold u_uv (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_in(supply_low_evt),
      .clr_in(clr_faults),
      .flag(f_uv)
   );
   gss_fault_hold u_any (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_in(supply_high_evt | supply_low_evt),
      .clr_in(clr_faults),
      .flag(f_any)
   );
   gss_fault_hold u_mv1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_in(position_step_g1),
      .clr_in(clr_faults),
      .flag(f_mv1)
   );
   gss_fault_hold u_mv0 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_in(position_step_g0),
      .clr_in(clr_faults),
      .flag(f_mv0)
   );

   // assemble the device status word from live and held state
   always_comb begin
      dev_word = '0;
      dev_word[B_HEAD1] = heading_g1;
      dev_word[B_HEAD0] = heading_g0;
      dev_word[B_ZS1] = zero_side_g1;
      dev_word[B_ZS0] = zero_side_g0;
      dev_word[B_TP1] = target_pending_g1;
      dev_word[B_TP0] = target_pending_g0;
      dev_word[B_OV] = f_ov;
      dev_word[B_UV] = f_uv;
      dev_word[B_CAL] = clk_cal_bad;
      dev_word[B_ANY] = f_any;
      dev_word[B_POSITION_CHANGED_G1] = f_mv1;
      dev_word[B_POSITION_CHANGED_G0] = f_mv0;
      dev_word[B_HOME1] = homing_active_g1;
      dev_word[B_HOME0] = homing_active_g0;
      dev_word[B_OT1] = s_q.ot[1];
      dev_word[B_OT0] = s_q.ot[0];
   end

   // pick the status word by the held select field
   always_comb begin
      case (gss_decode(s_q.sel))
         GSS_DEVICE: sel_word = dev_word;
         GSS_ACCUM: sel_word = accum_word;
         GSS_POS0: sel_word = pos_word_g0;
         GSS_POS1: sel_word = pos_word_g1;
         GSS_VEL: sel_word = vel_word;
         default: sel_word = dev_word;
      endcase
   end

   // frame sequencing, shifting and message acceptance
   always_comb begin
      s_d = s_q;
      s_d.sclk_p = sclk;
      s_d.mvalid = 1'b0;
      // thermal trip holds until the gauge is enabled again
      if (enable_g1_evt) s_d.ot[1] = 1'b0;
      if (enable_g0_evt) s_d.ot[0] = 1'b0;
      if (thermal_evt_g1) s_d.ot[1] = 1'b1;
      if (thermal_evt_g0) s_d.ot[0] = 1'b1;
      // overvoltage kills drivers; deep undervoltage also resets motion
      s_d.drv_off = f_ov | supply_high_evt | supply_deep_low;
      s_d.mreset = supply_deep_low;
      if (cs_fall) begin
         // load selected word and present its msb
         s_d.in_frame = 1'b1;
         // keep the whole word: the first rise shifts bit 15 out of the
         // top, so the first fall presents bit 14, and after sixteen
         // rises only received bits remain for the echo
         s_d.shreg = sel_word;
         s_d.so = sel_word[15];
         s_d.oe_n = 1'b0;
         s_d.nbits = '0;
         s_d.dev_sel_frame = (gss_decode(s_q.sel) == GSS_DEVICE);
      end else if (cs_rise) begin
         // release so; accept only whole words
         s_d.in_frame = 1'b0;
         s_d.oe_n = 1'b1;
         s_d.so = 1'b0;
         if (len_ok) begin
            s_d.mvalid = 1'b1;
            s_d.mword = s_q.rxw;
            s_d.sel = s_q.rxw[SEL_HI:SEL_LO];
         end
      end else if (s_q.in_frame && !cs_n) begin
         if (sclk_rise) begin
            // sample si into both the receive word and the echo path
            s_d.rxw = {s_q.rxw[14:0], si};
            s_d.shreg = {s_q.shreg[14:0], si};
            if (s_q.nbits != '1) s_d.nbits = s_q.nbits + 1'b1;
         end else if (sclk_fall) begin
            s_d.so = s_q.shreg[15];
         end
      end
   end

   // register all of s_q; the instances register their own state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.oe_n <= 1'b1;
         s_q.sclk_p <= 1'b0;
         s_q.sel <= SEL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flip-flops
   assign so_o = s_q.so;
   assign so_oe_n = s_q.oe_n;
   assign drivers_off = s_q.drv_off;
   assign motion_reset = s_q.mreset;
   assign msg_valid = s_q.mvalid;
   assign msg_word = s_q.mword;
   assign status_select_field = s_q.sel;
endmodule

// >>> sim/gss_status_spi_checker.sv
// assertions on the ports of the status readback block
// assumes the port names of gss_status_spi; attached by bind below
module gss_status_spi_checker
   import gss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic so_o,
   input wire logic so_oe_n,
   input wire logic heading_g1,
   input wire logic supply_high_evt,
   input wire logic supply_deep_low,
   input wire logic drivers_off,
   input wire logic motion_reset,
   input wire logic msg_valid,
   input wire logic [15:0] msg_word,
   input wire logic [3:0] status_select_field
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // frame start turns the output driver on
   AST_SO_ON: assert property ($fell(cs_n) |=> !so_oe_n)
      else $error("so not driven at frame start");
   // device word goes out msb first
   AST_MSB: assert property ($fell(cs_n) && !status_select_field[3]
      |=> so_o == $past(heading_g1)) else $error("device msb wrong");
   // outside a frame the pin is released
   AST_SO_OFF: assert property (cs_n && $past(cs_n) |-> so_oe_n)
      else $error("so driven while deselected");
   // acceptance only right after deselect
   AST_VALID: assert property (msg_valid |-> $past(cs_n) && !$past(cs_n, 2))
      else $error("accept pulse out of place");
   // select changes only with an accepted message
   AST_SEL_HOLD: assert property (!$stable(status_select_field) |-> msg_valid)
      else $error("select changed without valid message");
   // select follows the received field
   AST_SEL_LOAD: assert property (msg_valid |->
      status_select_field == msg_word[11:8]) else $error("select not loaded");
   // overvoltage shuts the drivers off
   AST_OV_OFF: assert property (supply_high_evt |=> drivers_off ##1 drivers_off)
      else $error("drivers not off on overvoltage");
   // deep undervoltage resets motion
   AST_DEEP: assert property (supply_deep_low |=> motion_reset)
      else $error("motion not reset on deep low");
endmodule
bind gss_status_spi gss_status_spi_checker CHK (
   .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .so_o(so_o),
   .so_oe_n(so_oe_n), .heading_g1(heading_g1),
   .supply_high_evt(supply_high_evt), .supply_deep_low(supply_deep_low),
   .drivers_off(drivers_off), .motion_reset(motion_reset),
   .msg_valid(msg_valid), .msg_word(msg_word),
   .status_select_field(status_select_field)
);

// >>> sim/gss_spi_master.sv
// spi master model, mode 0, sampling so on each sclk rise
// assumes the bench calls xfer; pins move 1 ns after sys_clk rises
module gss_spi_master (
   input wire logic sys_clk,
   input wire logic so_o,
   input wire logic so_oe_n,
   output logic cs_n,
   output logic sclk,
   output logic si
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle: deselected, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // wait n edges, then step off the sampling edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // n bits of tx, msb first; a released so reads as unknown
   task automatic xfer(input int n, input logic [31:0] tx,
      output logic [31:0] rx);
      rx = '0;
      cs_n = 1'b0;
      tick(2);
      for (int i = n - 1; i >= 0; i--) begin
         si = tx[i];
         tick(3);
         sclk = 1'b1;
         rx = {rx[30:0], (so_oe_n ? 1'bx : so_o)};
         tick(2);
         sclk = 1'b0;
      end
      tick(2);
      cs_n = 1'b1;
      si = ~si; // released data line shows no stale value
      tick(3);
   endtask
endmodule

// >>> sim/gss_status_spi_test.sv
// self-checking bench for the status readback block
// assumes gss_spi_master as the far side and the bound checker
module gss_status_spi_test
   import gss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, rst_n = 1'b0, cs_n, sclk, si, so_o, so_oe_n;
   logic deep = 1'b0, drivers_off, motion_reset, msg_valid;
   logic [8:0] lv = '0; // live levels, bit 15 side first
   logic [7:0] ev = '0; // ov uv mv1 mv0 ot1 ot0 en1 en0
   logic [15:0] aw = 16'h4a5c, p0 = 16'h9c31, p1 = 16'h27e6, vw = 16'hd10b;
   logic [15:0] msg_word, e;
   logic [3:0] status_select_field;
   logic [15:0] q[$]; // expected accepted words
   int error_cnt = 0, checks = 0, seed = 32'h53f8533d;
   always #50 sys_clk = ~sys_clk;
   gss_spi_master M (.sys_clk(sys_clk), .so_o(so_o), .so_oe_n(so_oe_n),
      .cs_n(cs_n), .sclk(sclk), .si(si));
   gss_status_spi DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
      .sclk(sclk), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
      .heading_g1(lv[8]), .heading_g0(lv[7]), .zero_side_g1(lv[6]),
      .zero_side_g0(lv[5]), .target_pending_g1(lv[4]),
      .target_pending_g0(lv[3]), .clk_cal_bad(lv[2]),
      .homing_active_g1(lv[1]), .homing_active_g0(lv[0]),
      .accum_word(aw), .pos_word_g0(p0), .pos_word_g1(p1), .vel_word(vw),
      .supply_high_evt(ev[7]), .supply_low_evt(ev[6]),
      .supply_deep_low(deep), .position_step_g1(ev[5]),
      .position_step_g0(ev[4]), .thermal_evt_g1(ev[3]),
      .thermal_evt_g0(ev[2]), .enable_g1_evt(ev[1]), .enable_g0_evt(ev[0]),
      .drivers_off(drivers_off), .motion_reset(motion_reset),
      .msg_valid(msg_valid), .msg_word(msg_word),
      .status_select_field(status_select_field));
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // device word from live levels and flags ov uv any mv1 mv0 ot1 ot0
   function automatic logic [15:0] dev(input logic [6:0] f);
      return {lv[8:3], f[6:5], lv[2], f[4:2], lv[1:0], f[1:0]};
   endfunction
   // one frame of n bits carrying select code sel; ex is the word read
   task automatic frame(input int n, input logic [3:0] sel,
      input logic [15:0] ex);
      logic [31:0] tx, rx;
      tx = $random(seed);
      tx[11:8] = sel;
      if (n % 16 == 0) q.push_back(tx[15:0]);
      M.xfer(n, tx, rx);
      if (n >= 16) chk(rx[n-1 -: 16], ex);
      if (n == 32) chk(rx[15:0], tx[31:16]);
   endtask
   // event pulse of one cycle
   task automatic pulse(input logic [7:0] x);
      ev = x;
      M.tick(1);
      ev = '0;
      M.tick(1);
   endtask
   // verdict and end of run
   task automatic close_out;
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // watcher: each accepted message against the oldest note
   always @(posedge sys_clk) begin
      #2;
      if (msg_valid === 1'b1) begin
         e = (q.size() != 0) ? q.pop_front() : ~msg_word;
         chk(msg_word, e);
         chk({12'h0, status_select_field}, {12'h0, e[11:8]});
      end
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      close_out();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      M.tick(2);
      lv = $random(seed);
      frame(16, 4'h3, dev(7'h00));
      pulse(8'hfc);
      chk({15'h0, drivers_off}, 16'h1);
      frame(8, 4'h8, 16'h0);
      lv = $random(seed);
      frame(16, 4'h0, dev(7'h7f));
      lv = $random(seed);
      frame(16, 4'h8, dev(7'h03));
      pulse(8'h03);
      pulse(8'h80);
      frame(32, 4'hc, aw);
      frame(16, 4'hd, p0);
      frame(16, 4'he, p1);
      frame(16, 4'h7, vw);
      lv = $random(seed);
      frame(16, 4'h0, dev(7'h50));
      pulse(8'h03);
      frame(16, 4'h0, dev(7'h00));
      deep = 1'b1;
      M.tick(2);
      chk({15'h0, motion_reset}, 16'h1);
      deep = 1'b0;
      M.tick(3);
      chk(16'(q.size()), 16'h0);
      close_out();
   end
endmodule
